// ==== shared/cbfle_alu_if.sv ====
/*
   Carrier between the execution core and its flag and branch unit.
   Assumes both ends sit on the same clock; the unit is combinational.
*/
`timescale 1ns/1ps
interface cbfle_alu_if;
   import cbfle_pkg::*;
   cbfle_op_t   op;
   logic [7:0]  operand;
   logic [2:0]  bitSel;
   logic [7:0]  flags;
   logic [6:0]  offset;
   logic [15:0] pc;
   logic [7:0]  result;
   logic [7:0]  flagsNxt;
   logic        taken;
   logic [15:0] target;

   modport core (output op, operand, bitSel, flags, offset, pc,
                 input  result, flagsNxt, taken, target);
   modport alu  (input  op, operand, bitSel, flags, offset, pc,
                 output result, flagsNxt, taken, target);
endinterface

// ==== shared/cbfle_consts.svh ====
/*
   Offsets, field positions, flag positions and reset values of the
   bit, flag and load execution block.
   Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef CBFLE_CONSTS_SVH
`define CBFLE_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CBFLE_OFF_INSTR     12'h000
`define CBFLE_OFF_FLAGS     12'h004
`define CBFLE_OFF_PC        12'h008
`define CBFLE_OFF_GSEL      12'h00C
`define CBFLE_OFF_GDATA     12'h010

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define CBFLE_F_OP_MSB      4
`define CBFLE_F_OP_LSB      0
`define CBFLE_F_REG_MSB     9
`define CBFLE_F_REG_LSB     5
`define CBFLE_F_BIT_MSB     12
`define CBFLE_F_BIT_LSB     10
`define CBFLE_F_PTR_MSB     14
`define CBFLE_F_PTR_LSB     13
`define CBFLE_F_DISP_MSB    20
`define CBFLE_F_DISP_LSB    15
`define CBFLE_F_IO_MSB      19
`define CBFLE_F_IO_LSB      15
`define CBFLE_F_OFS_MSB     27
`define CBFLE_F_OFS_LSB     21

// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define CBFLE_FLAG_C        0
`define CBFLE_FLAG_Z        1
`define CBFLE_FLAG_N        2
`define CBFLE_FLAG_V        3
`define CBFLE_FLAG_S        4
`define CBFLE_FLAG_H        5
`define CBFLE_FLAG_T        6
`define CBFLE_FLAG_I        7
`define CBFLE_STAT_BUSY     8

// ----------------------------------------
// Reset values and pointer bases
// ----------------------------------------
`define CBFLE_FLAGS_RST     8'h00
`define CBFLE_PC_RST        16'h0000
`define CBFLE_GPR_RST       8'h00
`define CBFLE_PTR_X         5'h1A
`define CBFLE_PTR_Y         5'h1C
`define CBFLE_PTR_Z         5'h1E

`endif

// ==== shared/cbfle_pkg.sv ====
/*
   Types of the bit, flag and load execution block: opcodes and states.
   Assumes nothing beyond the consts header for numbers.
*/
package cbfle_pkg;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   typedef enum logic [4:0] {
      CBFLE_OP_NOP          = 5'h00,
      CBFLE_OP_BR_NO_OVF    = 5'h01,
      CBFLE_OP_BR_IRQ_EN    = 5'h02,
      CBFLE_OP_BR_IRQ_DIS   = 5'h03,
      CBFLE_OP_IO_BIT_SET   = 5'h04,
      CBFLE_OP_IO_BIT_CLR   = 5'h05,
      CBFLE_OP_ROT_RIGHT    = 5'h06,
      CBFLE_OP_COPY_TO_T    = 5'h07,
      CBFLE_OP_LOAD_FROM_T  = 5'h08,
      CBFLE_OP_SET_OVF      = 5'h09,
      CBFLE_OP_CLR_OVF      = 5'h0A,
      CBFLE_OP_SET_HALF     = 5'h0B,
      CBFLE_OP_CLR_HALF     = 5'h0C,
      CBFLE_OP_SET_SIGN     = 5'h0D,
      CBFLE_OP_CLR_SIGN     = 5'h0E,
      CBFLE_OP_LOAD_PREDEC  = 5'h0F,
      CBFLE_OP_LOAD_POSTINC = 5'h10,
      CBFLE_OP_LOAD_DISP    = 5'h11
   } cbfle_op_t;

   typedef enum logic [1:0] {
      CBFLE_ST_IDLE  = 2'b00,
      CBFLE_ST_EXEC  = 2'b01,
      CBFLE_ST_EXEC2 = 2'b10
   } cbfle_state_t;

endpackage

// ==== src/cbfle_alu.sv ====
/*
   Flag and branch unit: rotate, bit transfer, flag set/clear, branch test.
   Assumes the core presents a stable decoded instruction; purely combinational.
*/
`timescale 1ns/1ps
`include "cbfle_consts.svh"

module cbfle_alu
   import cbfle_pkg::*;
(
   cbfle_alu_if.alu aluBus
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] putBit(input logic [7:0] v, input logic [2:0] idx, input logic b);
      logic [7:0] o;
      o      = v;
      o[idx] = b;
      return o;
   endfunction

   // ----------------------------------------
   // Evaluation
   // ----------------------------------------
   always_comb
   begin
      aluBus.result   = aluBus.operand;
      aluBus.flagsNxt = aluBus.flags;
      aluBus.taken    = 1'b0;
      // Sign extension lets a taken branch move backward
      aluBus.target   = aluBus.pc + {{9{aluBus.offset[6]}}, aluBus.offset} + 16'h0001;
      unique case (aluBus.op)
         CBFLE_OP_BR_NO_OVF:  aluBus.taken = ~aluBus.flags[`CBFLE_FLAG_V];
         CBFLE_OP_BR_IRQ_EN:  aluBus.taken = aluBus.flags[`CBFLE_FLAG_I];
         CBFLE_OP_BR_IRQ_DIS: aluBus.taken = ~aluBus.flags[`CBFLE_FLAG_I];
         CBFLE_OP_ROT_RIGHT:
         begin
            aluBus.result                   = {aluBus.flags[`CBFLE_FLAG_C], aluBus.operand[7:1]};
            aluBus.flagsNxt[`CBFLE_FLAG_C] = aluBus.operand[0];
            aluBus.flagsNxt[`CBFLE_FLAG_N] = aluBus.flags[`CBFLE_FLAG_C];
            aluBus.flagsNxt[`CBFLE_FLAG_Z] = ({aluBus.flags[`CBFLE_FLAG_C], aluBus.operand[7:1]} == 8'h00);
            aluBus.flagsNxt[`CBFLE_FLAG_V] = aluBus.flags[`CBFLE_FLAG_C] ^ aluBus.operand[0];
         end
         CBFLE_OP_COPY_TO_T:   aluBus.flagsNxt[`CBFLE_FLAG_T] = aluBus.operand[aluBus.bitSel];
         CBFLE_OP_LOAD_FROM_T: aluBus.result = putBit(aluBus.operand, aluBus.bitSel,
                                                       aluBus.flags[`CBFLE_FLAG_T]);
         CBFLE_OP_SET_OVF:  aluBus.flagsNxt[`CBFLE_FLAG_V] = 1'b1;
         CBFLE_OP_CLR_OVF:  aluBus.flagsNxt[`CBFLE_FLAG_V] = 1'b0;
         CBFLE_OP_SET_HALF: aluBus.flagsNxt[`CBFLE_FLAG_H] = 1'b1;
         CBFLE_OP_CLR_HALF: aluBus.flagsNxt[`CBFLE_FLAG_H] = 1'b0;
         CBFLE_OP_SET_SIGN: aluBus.flagsNxt[`CBFLE_FLAG_S] = 1'b1;
         CBFLE_OP_CLR_SIGN: aluBus.flagsNxt[`CBFLE_FLAG_S] = 1'b0;
         default: ;
      endcase
   end

endmodule // cbfle_alu

// ==== src/cbfle_top.sv ====
/*
   Execution block for branch, I/O bit, rotate, bit transfer, flag and
   indirect load instructions, with an APB register window.
   Assumes data memory returns read data in the cycle its read strobe is
   high, and the I/O space applies a bit write in the strobe's cycle.
*/
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "cbfle_consts.svh"

module cbfle_top
   import cbfle_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             memRd,
   output logic      [15:0] memAddr,
   input  wire logic [7:0]  memRdata,
   output logic             ioBitWe,
   output logic      [4:0]  ioAddr,
   output logic      [2:0]  ioBitSel,
   output logic             ioBitVal
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   cbfle_state_t state_r;
   logic [31:0]  instr_r;
   logic [7:0]   flags_r;
   logic [15:0]  pc_r;
   logic [4:0]   gsel_r;
   logic [7:0]   regs_r [32];
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic         memRd_r;
   logic [15:0]  memAddr_r;
   logic         ioBitWe_r;
   logic [4:0]   ioAddr_r;
   logic [2:0]   ioBitSel_r;
   logic         ioBitVal_r;

   cbfle_alu_if  aluBus ();
   cbfle_op_t    op;
   logic [4:0]   dest;
   logic [4:0]   ptrIdx;
   logic [15:0]  ptrVal;
   logic [7:0]   curOperand;
   logic         busy;
   logic         apbDone;
   logic         apbWr;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [4:0] ptrBase(input logic [1:0] sel);
      unique case (sel)
         2'b00:   return `CBFLE_PTR_X;
         2'b01:   return `CBFLE_PTR_Y;
         default: return `CBFLE_PTR_Z;
      endcase
   endfunction

   function automatic logic isMapped(input logic [11:0] a);
      return (a == `CBFLE_OFF_INSTR) || (a == `CBFLE_OFF_FLAGS) || (a == `CBFLE_OFF_PC) ||
             (a == `CBFLE_OFF_GSEL) || (a == `CBFLE_OFF_GDATA);
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign op         = cbfle_op_t'(instr_r[`CBFLE_F_OP_MSB:`CBFLE_F_OP_LSB]);
   assign dest       = instr_r[`CBFLE_F_REG_MSB:`CBFLE_F_REG_LSB];
   assign ptrIdx     = ptrBase(instr_r[`CBFLE_F_PTR_MSB:`CBFLE_F_PTR_LSB]);
   assign ptrVal     = {regs_r[ptrIdx + 5'h01], regs_r[ptrIdx]};
   assign curOperand = regs_r[dest];
   assign busy       = (state_r != CBFLE_ST_IDLE);
   assign apbDone    = psel & penable & pready_r;
   assign apbWr      = apbDone & pwrite & ~pslverr_r;

   assign aluBus.op      = op;
   assign aluBus.operand = curOperand;
   assign aluBus.bitSel  = instr_r[`CBFLE_F_BIT_MSB:`CBFLE_F_BIT_LSB];
   assign aluBus.flags   = flags_r;
   assign aluBus.offset  = instr_r[`CBFLE_F_OFS_MSB:`CBFLE_F_OFS_LSB];
   assign aluBus.pc      = pc_r;

   cbfle_alu u_alu (
      .aluBus (aluBus.alu)
   );

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state so read data and error come from flops
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= psel & penable & ~pready_r;
         if (psel & penable & ~pready_r)
         begin
            // Writes while executing are refused so the instruction sees stable state
            pslverr_r <= ~isMapped(paddr) | (pwrite & busy);
            unique case (paddr)
               `CBFLE_OFF_INSTR: prdata_r <= instr_r;
               `CBFLE_OFF_FLAGS: prdata_r <= {23'h000000, busy, flags_r};
               `CBFLE_OFF_PC:    prdata_r <= {16'h0000, pc_r};
               `CBFLE_OFF_GSEL:  prdata_r <= {27'h0000000, gsel_r};
               `CBFLE_OFF_GDATA: prdata_r <= {24'h000000, regs_r[gsel_r]};
               default:          prdata_r <= 32'h0000_0000;
            endcase
         end
         else
         begin
            pslverr_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         gsel_r <= 5'h00;
      else if (apbWr && paddr == `CBFLE_OFF_GSEL)
         gsel_r <= pwdata[4:0];
   end

   // ----------------------------------------
   // Sequencer and program counter
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= CBFLE_ST_IDLE;
         instr_r <= 32'h0000_0000;
         pc_r    <= `CBFLE_PC_RST;
      end
      else
      begin
         unique case (state_r)
            CBFLE_ST_IDLE:
            begin
               if (apbWr && paddr == `CBFLE_OFF_INSTR)
               begin
                  instr_r <= pwdata;
                  state_r <= CBFLE_ST_EXEC;
               end
               else if (apbWr && paddr == `CBFLE_OFF_PC)
                  pc_r <= pwdata[15:0];
            end
            CBFLE_ST_EXEC:
            begin
               unique case (op)
                  CBFLE_OP_BR_NO_OVF, CBFLE_OP_BR_IRQ_EN, CBFLE_OP_BR_IRQ_DIS:
                  begin
                     // Taken branch spends a second cycle refilling
                     pc_r    <= aluBus.taken ? aluBus.target : pc_r + 16'h0001;
                     state_r <= aluBus.taken ? CBFLE_ST_EXEC2 : CBFLE_ST_IDLE;
                  end
                  CBFLE_OP_IO_BIT_SET, CBFLE_OP_IO_BIT_CLR, CBFLE_OP_LOAD_PREDEC,
                  CBFLE_OP_LOAD_POSTINC, CBFLE_OP_LOAD_DISP:
                     state_r <= CBFLE_ST_EXEC2;
                  default:
                  begin
                     pc_r    <= pc_r + 16'h0001;
                     state_r <= CBFLE_ST_IDLE;
                  end
               endcase
            end
            CBFLE_ST_EXEC2:
            begin
               if (op != CBFLE_OP_BR_NO_OVF && op != CBFLE_OP_BR_IRQ_EN && op != CBFLE_OP_BR_IRQ_DIS)
                  pc_r <= pc_r + 16'h0001;
               state_r <= CBFLE_ST_IDLE;
            end
            default: state_r <= CBFLE_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         flags_r <= `CBFLE_FLAGS_RST;
      else if (apbWr && paddr == `CBFLE_OFF_FLAGS)
         flags_r <= pwdata[7:0];
      else if (state_r == CBFLE_ST_EXEC)
         flags_r <= aluBus.flagsNxt;
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 32; i++)
            regs_r[i] <= `CBFLE_GPR_RST;
      end
      else if (apbWr && paddr == `CBFLE_OFF_GDATA)
         regs_r[gsel_r] <= pwdata[7:0];
      else if (state_r == CBFLE_ST_EXEC)
      begin
         if (op == CBFLE_OP_ROT_RIGHT || op == CBFLE_OP_LOAD_FROM_T)
            regs_r[dest] <= aluBus.result;
         else if (op == CBFLE_OP_LOAD_PREDEC)
         begin
            regs_r[ptrIdx]         <= ptrVal[7:0] - 8'h01;
            regs_r[ptrIdx + 5'h01] <= ptrVal[15:8] - {7'h00, ptrVal[7:0] == 8'h00};
         end
      end
      else if (state_r == CBFLE_ST_EXEC2 && memRd_r)
      begin
         if (op == CBFLE_OP_LOAD_POSTINC)
         begin
            regs_r[ptrIdx]         <= memAddr_r[7:0] + 8'h01;
            regs_r[ptrIdx + 5'h01] <= memAddr_r[15:8] + {7'h00, memAddr_r[7:0] == 8'hFF};
         end
         // Destination wins if it overlaps the pointer
         regs_r[dest] <= memRdata;
      end
   end

   // ----------------------------------------
   // Data memory port
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         memRd_r   <= 1'b0;
         memAddr_r <= 16'h0000;
      end
      else if (state_r == CBFLE_ST_EXEC)
      begin
         memRd_r <= (op == CBFLE_OP_LOAD_PREDEC) || (op == CBFLE_OP_LOAD_POSTINC) || (op == CBFLE_OP_LOAD_DISP);
         unique case (op)
            CBFLE_OP_LOAD_PREDEC: memAddr_r <= ptrVal - 16'h0001;
            CBFLE_OP_LOAD_DISP:   memAddr_r <= ptrVal + {10'h000, instr_r[`CBFLE_F_DISP_MSB:`CBFLE_F_DISP_LSB]};
            default:              memAddr_r <= ptrVal;
         endcase
      end
      else
         memRd_r <= 1'b0;
   end

   // ----------------------------------------
   // I/O bit port
   // ----------------------------------------
   // Only the addressed bit is written, so write-one-to-clear neighbours survive
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ioBitWe_r  <= 1'b0;
         ioAddr_r   <= 5'h00;
         ioBitSel_r <= 3'h0;
         ioBitVal_r <= 1'b0;
      end
      else
      begin
         ioBitWe_r <= (state_r == CBFLE_ST_EXEC) &&
                      (op == CBFLE_OP_IO_BIT_SET || op == CBFLE_OP_IO_BIT_CLR);
         if (state_r == CBFLE_ST_EXEC)
         begin
            ioAddr_r   <= instr_r[`CBFLE_F_IO_MSB:`CBFLE_F_IO_LSB];
            ioBitSel_r <= instr_r[`CBFLE_F_BIT_MSB:`CBFLE_F_BIT_LSB];
            ioBitVal_r <= (op == CBFLE_OP_IO_BIT_SET);
         end
      end
   end

   assign prdata   = prdata_r;
   assign pready   = pready_r;
   assign pslverr  = pslverr_r;
   assign memRd    = memRd_r;
   assign memAddr  = memAddr_r;
   assign ioBitWe  = ioBitWe_r;
   assign ioAddr   = ioAddr_r;
   assign ioBitSel = ioBitSel_r;
   assign ioBitVal = ioBitVal_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic inExec;
   assign inExec = (state_r == CBFLE_ST_EXEC);
   // Load data overwrites an overlapping pointer, so pointer checks skip that case
   logic ptrHit;
   assign ptrHit = (dest == ptrIdx) || (dest == ptrIdx + 5'h01);

   AST_BR_OVF_TAKEN: assert property (inExec && op == CBFLE_OP_BR_NO_OVF && !flags_r[`CBFLE_FLAG_V]
      |=> pc_r == $past(aluBus.target) && state_r == CBFLE_ST_EXEC2 ##1 state_r == CBFLE_ST_IDLE)
      else $error("overflow branch not taken in two cycles");
   AST_BR_OVF_SKIP: assert property (inExec && op == CBFLE_OP_BR_NO_OVF && flags_r[`CBFLE_FLAG_V]
      |=> pc_r == $past(pc_r) + 16'h0001 && state_r == CBFLE_ST_IDLE)
      else $error("overflow branch did not fall through");
   AST_BR_IRQ: assert property (inExec && (op == CBFLE_OP_BR_IRQ_EN || op == CBFLE_OP_BR_IRQ_DIS)
      |=> flags_r == $past(flags_r) && (state_r == CBFLE_ST_EXEC2) == $past(aluBus.taken))
      else $error("interrupt branch wrong");
   AST_IO_BIT: assert property (inExec && op == CBFLE_OP_IO_BIT_SET
      |=> ioBitWe_r && ioBitVal_r && $stable(flags_r) ##1 !ioBitWe_r && state_r == CBFLE_ST_IDLE)
      else $error("io bit set not a two cycle single strobe");
   AST_ROT: assert property (inExec && op == CBFLE_OP_ROT_RIGHT
      |=> flags_r[`CBFLE_FLAG_C] == $past(curOperand[0]) && flags_r[`CBFLE_FLAG_N] == $past(flags_r[`CBFLE_FLAG_C])
          && state_r == CBFLE_ST_IDLE)
      else $error("rotate carry wrong");
   AST_COPY_T: assert property (inExec && op == CBFLE_OP_COPY_TO_T
      |=> flags_r[`CBFLE_FLAG_T] == $past(aluBus.operand[aluBus.bitSel])
          && flags_r[5:0] == $past(flags_r[5:0]))
      else $error("transfer flag copy wrong");
   AST_LOAD_T: assert property (inExec && op == CBFLE_OP_LOAD_FROM_T |=> $stable(flags_r))
      else $error("bit load touched flags");
   AST_OVF: assert property (inExec && op == CBFLE_OP_SET_OVF |=> flags_r[`CBFLE_FLAG_V]
      && flags_r[2:0] == $past(flags_r[2:0]))
      else $error("overflow set wrong");
   AST_HALF: assert property (inExec && op == CBFLE_OP_CLR_HALF |=> !flags_r[`CBFLE_FLAG_H]
      && flags_r[4:0] == $past(flags_r[4:0]))
      else $error("half carry clear wrong");
   AST_SIGN: assert property (inExec && op == CBFLE_OP_SET_SIGN |=> flags_r[`CBFLE_FLAG_S]
      && flags_r[3:0] == $past(flags_r[3:0]))
      else $error("sign set wrong");
   AST_PREDEC: assert property (inExec && op == CBFLE_OP_LOAD_PREDEC
      |=> memRd_r && memAddr_r == $past(ptrVal) - 16'h0001 ##1 state_r == CBFLE_ST_IDLE)
      else $error("pre-decrement load address wrong");
   AST_POSTINC: assert property (inExec && op == CBFLE_OP_LOAD_POSTINC && !ptrHit
      |=> memRd_r && memAddr_r == $past(ptrVal) ##1 ptrVal == $past(memAddr_r) + 16'h0001)
      else $error("post-increment load wrong");
   AST_DISP: assert property (inExec && op == CBFLE_OP_LOAD_DISP && !ptrHit
      |=> memRd_r && $stable(ptrVal) ##1 $stable(ptrVal) && $stable(flags_r))
      else $error("displacement load moved pointer");

   COV_BR_TAKEN: cover property (inExec && aluBus.taken ##2 state_r == CBFLE_ST_IDLE);
   COV_LOAD:     cover property (memRd_r ##1 state_r == CBFLE_ST_IDLE);
   COV_IO:       cover property (ioBitWe_r && !ioBitVal_r);

endmodule // cbfle_top

// ==== testbench/cbfle_mem_model.sv ====
/*
   Data memory and low I/O register model facing the execution block.
   Assumes read data is wanted in the strobe cycle and bit writes land at that edge.
*/
`timescale 1ns/1ps
module cbfle_mem_model
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        memRd,
   input  wire logic [15:0] memAddr,
   output logic      [7:0]  memRdata,
   input  wire logic        ioBitWe,
   input  wire logic [4:0]  ioAddr,
   input  wire logic [2:0]  ioBitSel,
   input  wire logic        ioBitVal
);
   logic [7:0] ioReg [32];
   logic [7:0] idleR;

   // Outside a strobe the bus shows a changing pattern, so stale data never passes
   assign memRdata = memRd ? (memAddr[7:0] ^ memAddr[15:8] ^ 8'h5A) : idleR;

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         idleR <= 8'hA5;
      else
         idleR <= ~idleR + 8'h01;

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         for (int i = 0; i < 32; i++) ioReg[i] <= 8'h00;
      else if (ioBitWe)
         ioReg[ioAddr][ioBitSel] <= ioBitVal;
endmodule // cbfle_mem_model

// ==== testbench/cbfle_top_tb.sv ====
/*
   Self-checking bench: random instructions compared with an integer model.
   Assumes the memory model's read pattern and one idle cycle between APB transfers.
*/
`timescale 1ns/1ps
`include "cbfle_consts.svh"
module cbfle_top_tb;
   import cbfle_pkg::*;
   localparam logic [11:0] OI = `CBFLE_OFF_INSTR, OF = `CBFLE_OFF_FLAGS, OP = `CBFLE_OFF_PC;
   localparam logic [11:0] OS = `CBFLE_OFF_GSEL, OD = `CBFLE_OFF_GDATA;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, memRd, ioBitWe, ioBitVal, errv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] memAddr, lastAddr, lfsrR;
   logic [7:0]  memRdata;
   logic [4:0]  ioAddr;
   logic [2:0]  ioBitSel;
   int          errorCnt, samplesChecked, rdCnt, weCnt, flg, pc, pc1, ptr, k, d, b, p, q, op, np, t, ea, r0, w0, n;
   int          rg[32], io[32];

   cbfle_top dut (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .memRd, .memAddr, .memRdata, .ioBitWe, .ioAddr, .ioBitSel, .ioBitVal);
   cbfle_mem_model pm (.core_clk, .rst, .memRd, .memAddr, .memRdata, .ioBitWe, .ioAddr, .ioBitSel, .ioBitVal);

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Strobes counted per instruction, so a missing or doubled access shows
   always @(posedge core_clk)
   begin
      if (memRd === 1'b1) lastAddr <= memAddr;
      rdCnt <= rdCnt + (memRd === 1'b1);
      weCnt <= weCnt + (ioBitWe === 1'b1);
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic endSim();
      $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic timeoutHit();
      errorCnt++;
      endSim();
   endtask

   // Answer is read at the rising edge that ends the access, before the slave flops move
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      int c;
      c = 0;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         c++;
      end while (pready !== 1'b1 && c < 50);
      if (pready !== 1'b1) timeoutHit();
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic setReg(input int i, input int v);
      apb(OS, 1'b1, i);
      apb(OD, 1'b1, v & 8'hFF);
      rg[i] = v & 8'hFF;
   endtask

   task automatic getReg(input int i);
      apb(OS, 1'b1, i);
      apb(OD, 1'b0, '0);
   endtask

   function automatic int rnd();
      lfsrR = {lfsrR[14:0], lfsrR[15] ^ lfsrR[13] ^ lfsrR[12] ^ lfsrR[10]};
      return int'(lfsrR);
   endfunction

   initial
   begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; lfsrR = 16'h0023;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      apb(12'h014, 1'b0, '0);
      check("unmapped error", errv, 1);
      check("unmapped data", rdv, 0);
      $display("unmapped access test done");
      for (int it = 0; it < 150; it++)
      begin
         t = rnd(); op = (it < 36) ? it % 18 : t % 18;
         t = rnd(); flg = t & 8'hFF; pc = rnd();
         t = rnd(); d = t % 32; b = (t >> 5) % 8; p = (t >> 8) % 4; q = (t >> 10) % 64;
         k = rnd(); np = (p == 0) ? 26 : (p == 1) ? 28 : 30;
         apb(OF, 1'b1, flg); apb(OP, 1'b1, pc);
         setReg(np, rnd()); setReg(np + 1, rnd()); setReg(d, rnd());
         r0 = rdCnt; w0 = weCnt;
         apb(OI, 1'b1, op | d << 5 | b << 10 | p << 13 | q << 15 | (k & 8'h7F) << 21);
         n = 0;
         do
         begin
            apb(OF, 1'b0, '0);
            n++;
         end while (rdv[8] !== 1'b0 && n < 20);
         if (n >= 20) timeoutHit();
         k = (k & 8'h7F) - ((k & 8'h40) << 1);
         ptr = rg[np] | rg[np + 1] << 8; pc1 = (pc + 1) & 16'hFFFF; ea = 0;
         case (op)
            1: if (!flg[3]) pc1 = (pc + k + 1) & 16'hFFFF;
            2: if (flg[7]) pc1 = (pc + k + 1) & 16'hFFFF;
            3: if (!flg[7]) pc1 = (pc + k + 1) & 16'hFFFF;
            4, 5: io[q % 32][b] = (op == 4);
            6: t = rg[d];
            7: flg = (flg & 8'hBF) | ((rg[d] >> b) & 1) << 6;
            8: rg[d] = (rg[d] & ~(1 << b)) | ((flg >> 6) & 1) << b;
            9: flg = flg | 8'h08;
            10: flg = flg & 8'hF7;
            11: flg = flg | 8'h20;
            12: flg = flg & 8'hDF;
            13: flg = flg | 8'h10;
            14: flg = flg & 8'hEF;
            15: ea = (ptr - 1) & 16'hFFFF;
            16: ea = ptr;
            17: ea = (ptr + q) & 16'hFFFF;
            default: ;
         endcase
         if (op == 6) rg[d] = (t >> 1) | (flg & 1) << 7;
         if (op == 6) flg = (flg & 8'hF0) | (t & 1) | (rg[d] == 0) << 1 | (flg & 1) << 2 | ((flg ^ t) & 1) << 3;
         if (op >= 15) ptr = (op == 15) ? ea : (op == 16) ? (ptr + 1) & 16'hFFFF : ptr;
         if (op >= 15) rg[np] = ptr & 8'hFF;
         if (op >= 15) rg[np + 1] = ptr >> 8;
         if (op >= 15) rg[d] = (ea & 8'hFF) ^ (ea >> 8) ^ 8'h5A;
         check("flags", rdv, flg);
         apb(OP, 1'b0, '0);
         check("pc", rdv, pc1);
         getReg(d);
         check("dest reg", rdv, rg[d]);
         getReg(np);
         check("pointer low", rdv, rg[np]);
         getReg(np + 1);
         check("pointer high", rdv, rg[np + 1]);
         check("io reg", pm.ioReg[q % 32], io[q % 32]);
         check("strobes", (rdCnt - r0) * 16 + weCnt - w0, (op >= 15) * 16 + (op == 4 || op == 5));
         if (op >= 15) check("read addr", lastAddr, ea);
      end
      $display("random instruction test done");
      endSim();
   end

   initial
   begin
      repeat (100000) @(posedge core_clk);
      timeoutHit();
   end
endmodule // cbfle_top_tb
